// File: reset_config_capture.sv
// Reset configuration capture with APB register access
`timescale 1ns/10ps
module reset_config_capture
  import config_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic        RESET_OVERRIDE_N,
  input  wire logic [15:0] DATA_IN,
  output      logic        DATA_PINS_INPUT,
  output      logic        UPPER_ADDR_AS_SELECTS,
  output      logic [7:0]  FEEDBACK_DIVIDER_VALUE,
  output      logic        LIMP_SELECT,
  output      logic        PAD_HIGH_DRIVE,
  output      logic [1:0]  BOOT_PORT_WIDTH,
  output      logic        CRYSTAL_BYPASS_SELECT,
  output      logic        FAST_CLOCK_SELECT,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [2:0]  PPROT,
  output      logic [31:0] PRDATA,
  output      logic        PREADY,
  output      logic        PSLVERR
);

  // ------------------------------------------------------------
  // Configuration capture
  // ------------------------------------------------------------
  logic [15:0] active_config_r;
  logic [15:0] active_config_nxt;
  logic [15:0] sampled_pins_r;
  logic        override_seen_r;
  phase_t      phase_r;
  logic [1:0]  release_cnt_r;

  function automatic logic [15:0] merge_override(input logic [15:0] pins);
    merge_override = (pins & OVERRIDE_MASK) | RESERVED_ONES;
  endfunction

  // Pins sampled every reset cycle, frozen after
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      sampled_pins_r  <= DATA_IN;
      override_seen_r <= ~RESET_OVERRIDE_N;
    end
  end

  // Active config updated only at reset end
  always_comb begin
    active_config_nxt = active_config_r;
    if (phase_r == PH_IN_RESET && !RESET) begin
      if (override_seen_r) begin
        active_config_nxt = merge_override(sampled_pins_r);
      end else begin
        active_config_nxt = ACTIVE_CONFIG_DEFAULT;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      active_config_r <= ACTIVE_CONFIG_DEFAULT;
    end else begin
      active_config_r <= active_config_nxt;
    end
  end

  // ------------------------------------------------------------
  // Pin direction after reset
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      phase_r       <= PH_IN_RESET;
      release_cnt_r <= 2'h0;
    end else begin
      case (phase_r)
        PH_IN_RESET: begin
          phase_r       <= PH_HOLD_INPUTS;
          release_cnt_r <= 2'h0;
        end
        PH_HOLD_INPUTS: begin
          release_cnt_r <= release_cnt_r + 2'h1;
          if (release_cnt_r + 2'h1 >= PIN_RELEASE_CYCLES) begin
            phase_r <= PH_RUN;
          end
        end
        PH_RUN: begin
          phase_r <= PH_RUN;
        end
        default: begin
          phase_r <= PH_IN_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      DATA_PINS_INPUT <= 1'b1;
    end else begin
      DATA_PINS_INPUT <= (phase_r != PH_RUN) &&
                         !(phase_r == PH_HOLD_INPUTS &&
                           release_cnt_r + 2'h1 >= PIN_RELEASE_CYCLES);
    end
  end

  // ------------------------------------------------------------
  // Decoded controls
  // ------------------------------------------------------------
  logic        dec_addr_sel;
  logic [7:0]  dec_divider;
  logic        dec_limp;
  logic        dec_pad;
  port_width_t dec_boot;
  logic        dec_bypass;
  logic        dec_fast;

  config_fields u_fields (
    .config_word            (active_config_nxt),
    .addr_as_selects        (dec_addr_sel),
    .feedback_divider_value (dec_divider),
    .limp_select            (dec_limp),
    .pad_high_drive         (dec_pad),
    .boot_port_width        (dec_boot),
    .crystal_bypass_select  (dec_bypass),
    .fast_clock_select      (dec_fast)
  );

  // Controls registered from the next active value
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      UPPER_ADDR_AS_SELECTS  <= ACTIVE_CONFIG_DEFAULT[BIT_UPPER_ADDR_SEL];
      FEEDBACK_DIVIDER_VALUE <= DIVIDER_BYPASS_ZERO;
      LIMP_SELECT            <= ACTIVE_CONFIG_DEFAULT[BIT_LIMP];
      PAD_HIGH_DRIVE         <= ACTIVE_CONFIG_DEFAULT[BIT_PAD_LOAD];
      BOOT_PORT_WIDTH        <= WIDTH_16;
      CRYSTAL_BYPASS_SELECT  <= ACTIVE_CONFIG_DEFAULT[BIT_BYPASS];
      FAST_CLOCK_SELECT      <= ACTIVE_CONFIG_DEFAULT[BIT_FAST_CLOCK];
    end else begin
      UPPER_ADDR_AS_SELECTS  <= dec_addr_sel;
      FEEDBACK_DIVIDER_VALUE <= dec_divider;
      LIMP_SELECT            <= dec_limp;
      PAD_HIGH_DRIVE         <= dec_pad;
      BOOT_PORT_WIDTH        <= dec_boot;
      CRYSTAL_BYPASS_SELECT  <= dec_bypass;
      FAST_CLOCK_SELECT      <= dec_fast;
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  logic        setup;
  logic        supervisor;
  logic [31:0] read_word;
  logic        addr_hit;

  assign setup      = PSEL && !PENABLE;
  assign supervisor = PPROT[0];

  // Identity shares a word with the default register
  always_comb begin
    read_word = 32'h0;
    addr_hit  = 1'b1;
    case ({PADDR[31:2], 2'b00})
      ADDR_ACTIVE_CONFIG: begin
        read_word = {16'h0, active_config_r};
      end
      ADDR_DEFAULT_CONFIG: begin
        read_word = {PART_NUMBER, REVISION_NUMBER, DEFAULT_CONFIG_RESET};
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
    if (PADDR == ADDR_IDENTITY) begin
      read_word = {16'h0, PART_NUMBER, REVISION_NUMBER};
    end
  end

  // No wait state: answer in the first access cycle
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
    end else if (setup) begin
      PREADY <= 1'b1;
      if (!supervisor || !addr_hit || PWRITE) begin
        PSLVERR <= 1'b1;
        PRDATA  <= 32'h0;
      end else begin
        PSLVERR <= 1'b0;
        PRDATA  <= read_word;
      end
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
    end
  end

endmodule

// File: config_pkg.sv
// Constants and types for the reset configuration capture block
package config_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses, low two bits ignored except for the identity address)
  // ------------------------------------------------------------
  localparam logic [31:0] ADDR_ACTIVE_CONFIG = 32'hFC0A0004;
  localparam logic [31:0] ADDR_DEFAULT_CONFIG = 32'hFC0A0008;
  localparam logic [31:0] ADDR_IDENTITY = 32'hFC0A000A;
  localparam logic [31:0] ADDR_IDENTITY_WORD = 32'hFC0A0008;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] ACTIVE_CONFIG_DEFAULT = 16'h012B;
  localparam logic [15:0] DEFAULT_CONFIG_RESET = 16'h0201;
  // Arbitrary identity values
  localparam logic [9:0] PART_NUMBER = 10'h155;
  localparam logic [5:0] REVISION_NUMBER = 6'h01;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_UPPER_ADDR_SEL = 9;
  localparam int BIT_RESERVED_ONE_HI = 8;
  localparam int BIT_MULT_SEL = 7;
  localparam int BIT_LIMP = 6;
  localparam int BIT_PAD_LOAD = 5;
  localparam int BIT_BOOT_HI = 4;
  localparam int BIT_BOOT_LO = 3;
  localparam int BIT_BYPASS = 2;
  localparam int BIT_FAST_CLOCK = 1;
  localparam int BIT_RESERVED_ONE_LO = 0;
  localparam int ID_PART_LO = 6;

  // Override pins D9, D7..D1
  localparam logic [15:0] OVERRIDE_MASK = 16'h02FE;
  localparam logic [15:0] RESERVED_ONES = 16'h0101;

  // Feedback divider values
  localparam logic [7:0] DIVIDER_BYPASS_ZERO = 8'h7D;
  localparam logic [7:0] DIVIDER_BYPASS_ONE = 8'h78;

  // Cycles the data pins stay inputs after the first cycle out of reset
  localparam logic [1:0] PIN_RELEASE_CYCLES = 2'h1;

  typedef enum logic [1:0] {
    WIDTH_32,
    WIDTH_16,
    WIDTH_8
  } port_width_t;

  typedef enum logic [1:0] {
    PH_IN_RESET,
    PH_HOLD_INPUTS,
    PH_RUN
  } phase_t;

endpackage

// File: config_fields.sv
// Decoder of configuration word into individual controls
`timescale 1ns/10ps
module config_fields
  import config_pkg::*;
(
  input  wire logic [15:0] config_word,
  output      logic        addr_as_selects,
  output      logic [7:0]  feedback_divider_value,
  output      logic        limp_select,
  output      logic        pad_high_drive,
  output      port_width_t boot_port_width,
  output      logic        crystal_bypass_select,
  output      logic        fast_clock_select
);

  always_comb begin
    addr_as_selects       = config_word[BIT_UPPER_ADDR_SEL];
    limp_select           = config_word[BIT_LIMP];
    pad_high_drive        = config_word[BIT_PAD_LOAD];
    crystal_bypass_select = config_word[BIT_BYPASS];
    fast_clock_select     = config_word[BIT_FAST_CLOCK];
    // Multiplier meaningful only in fast clock mode
    if (config_word[BIT_MULT_SEL]) begin
      feedback_divider_value = DIVIDER_BYPASS_ONE;
    end else begin
      feedback_divider_value = DIVIDER_BYPASS_ZERO;
    end
    case (config_word[BIT_BOOT_HI:BIT_BOOT_LO])
      2'h1:    boot_port_width = WIDTH_16;
      2'h2:    boot_port_width = WIDTH_8;
      default: boot_port_width = WIDTH_32;
    endcase
  end

endmodule

// File: config_capture_asserts.sv
// Assertions on the ports of the reset configuration capture block
`timescale 1ns/10ps
module config_capture_asserts
  import config_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RESET,
  input wire logic        RESET_OVERRIDE_N,
  input wire logic [15:0] DATA_IN,
  input wire logic        DATA_PINS_INPUT,
  input wire logic        UPPER_ADDR_AS_SELECTS,
  input wire logic [7:0]  FEEDBACK_DIVIDER_VALUE,
  input wire logic        FAST_CLOCK_SELECT,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [2:0]  PPROT,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  sequence apb_setup;
    PSEL && !PENABLE;
  endsequence
  sequence good_rd(a);
    apb_setup ##0 (PADDR == a && !PWRITE && PPROT[0]);
  endsequence
  AST_ANSWER: assert property (apb_setup |=> PREADY)
    else $error("no ready after setup");
  AST_WRITE_REFUSED: assert property (apb_setup ##0 PWRITE |=> PSLVERR)
    else $error("write not refused");
  AST_USER_REFUSED: assert property (apb_setup ##0 !PPROT[0] |=> PSLVERR && PRDATA == 0)
    else $error("user access not refused");
  AST_WORD_READ: assert property (good_rd(ADDR_IDENTITY_WORD) |=>
    PRDATA == {PART_NUMBER, REVISION_NUMBER, DEFAULT_CONFIG_RESET})
    else $error("identity or default word wrong");
  AST_RESERVED_BITS: assert property (good_rd(ADDR_ACTIVE_CONFIG) |=>
    PRDATA[15:10] == 0 && PRDATA[8] && PRDATA[0])
    else $error("reserved bits wrong");
  AST_DEFAULT_CAPTURE: assert property ($fell(RESET) && $past(RESET_OVERRIDE_N) |=>
    FEEDBACK_DIVIDER_VALUE == 8'h7D && FAST_CLOCK_SELECT && !UPPER_ADDR_AS_SELECTS)
    else $error("default config not taken");
  AST_OVERRIDE_CAPTURE: assert property ($fell(RESET) && !$past(RESET_OVERRIDE_N) |=>
    FAST_CLOCK_SELECT == $past(DATA_IN[1], 2) && UPPER_ADDR_AS_SELECTS == $past(DATA_IN[9], 2))
    else $error("override config not taken");
  AST_PINS_INPUT: assert property ($fell(RESET) |-> DATA_PINS_INPUT[*2] ##1 !DATA_PINS_INPUT)
    else $error("data pins input window wrong");
  AST_HOLD: assert property (!$past(RESET) && !$past(RESET, 2) |->
    $stable({UPPER_ADDR_AS_SELECTS, FEEDBACK_DIVIDER_VALUE, FAST_CLOCK_SELECT}))
    else $error("config changed after reset");
endmodule
bind reset_config_capture config_capture_asserts i_config_capture_asserts (
  .CLOCK(CLOCK), .RESET(RESET), .RESET_OVERRIDE_N(RESET_OVERRIDE_N), .DATA_IN(DATA_IN),
  .DATA_PINS_INPUT(DATA_PINS_INPUT), .UPPER_ADDR_AS_SELECTS(UPPER_ADDR_AS_SELECTS),
  .FEEDBACK_DIVIDER_VALUE(FEEDBACK_DIVIDER_VALUE), .FAST_CLOCK_SELECT(FAST_CLOCK_SELECT),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PPROT(PPROT),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR)
);

// File: override_model.sv
// Model of the external reset override circuitry
`timescale 1ns/10ps
module override_model
  import config_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_out,
  input  wire logic        ovr_en,
  input  wire logic [15:0] value,
  output      logic        override_n,
  output      logic [15:0] pins
);
  logic rel_r = 1'b0;
  always @(posedge clock) begin
    rel_r <= !reset_out;
    if (reset_out || !rel_r) begin
      override_n <= !ovr_en;
      pins <= value | ~OVERRIDE_MASK;
    end else begin
      // Released lines wander, no value held
      override_n <= !override_n;
      pins <= ~pins;
    end
  end
endmodule

// File: reset_config_capture_tb_top.sv
// Testbench for the reset configuration capture block
`timescale 1ns/10ps
module reset_config_capture_tb_top import config_pkg::*;;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        ovr_en = 1'b0;
  logic [15:0] value = 16'h0000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [2:0]  pprot = 3'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic        override_n, upper, limp, pad, bypass, fast, pins_in, pready, pslverr;
  logic [15:0] pins;
  logic [7:0]  divider;
  logic [1:0]  boot;
  logic [31:0] prdata;
  logic [31:0] seed = 32'd62189;
  logic [32:0] q[$];
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;
  localparam logic [32:0] ERR = 33'h100000000;

  override_model i_override_model (.clock(clock), .reset_out(reset), .ovr_en(ovr_en),
    .value(value), .override_n(override_n), .pins(pins));
  reset_config_capture i_reset_config_capture (.CLOCK(clock), .RESET(reset),
    .RESET_OVERRIDE_N(override_n), .DATA_IN(pins), .DATA_PINS_INPUT(pins_in),
    .UPPER_ADDR_AS_SELECTS(upper), .FEEDBACK_DIVIDER_VALUE(divider), .LIMP_SELECT(limp),
    .PAD_HIGH_DRIVE(pad), .BOOT_PORT_WIDTH(boot), .CRYSTAL_BYPASS_SELECT(bypass),
    .FAST_CLOCK_SELECT(fast), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PPROT(pprot), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr));

  initial begin
    forever #5 clock = ~clock;
  end

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  task check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task apb(input logic [31:0] a, input logic w, input logic [2:0] p, input logic [32:0] e);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {rnd(), rnd()};
    pprot <= p;
    q.push_back(e);
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(negedge clock) begin
    if (pready === 1'b1) begin
      check({pslverr, prdata}, q.pop_front());
    end
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task do_reset(input logic o, input logic [15:0] v);
    @(posedge clock);
    reset <= 1'b1;
    ovr_en <= o;
    value <= v;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task regs(input logic [15:0] c);
    apb(ADDR_ACTIVE_CONFIG, 1'b0, 3'h1, {17'h0, c});
    apb(ADDR_ACTIVE_CONFIG, 1'b1, 3'h1, ERR);
    apb(ADDR_ACTIVE_CONFIG, 1'b0, 3'h0, ERR);
    apb(ADDR_IDENTITY_WORD, 1'b0, 3'h1, {1'b0, PART_NUMBER, REVISION_NUMBER, DEFAULT_CONFIG_RESET});
    apb(32'hFC0A0010, 1'b0, 3'h1, ERR);
    apb(ADDR_ACTIVE_CONFIG, 1'b0, 3'h1, {17'h0, c});
    @(negedge clock);
    check(upper, c[9]);
    check(divider, c[7] ? 8'h78 : 8'h7D);
    check(limp, c[6]);
    check(pad, c[5]);
    check(boot, c[4:3] == 2'b11 ? 2'b00 : c[4:3]);
    check(bypass, c[2]);
    check(fast, c[1]);
  endtask

  initial begin
    logic [15:0] v;
    do_reset(1'b0, rnd());
    regs(ACTIVE_CONFIG_DEFAULT);
    $display("test default done");
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      v[4:3] = i[1:0];
      do_reset(i[2], v);
      regs(i[2] ? ((v & OVERRIDE_MASK) | RESERVED_ONES) : ACTIVE_CONFIG_DEFAULT);
      $display("test %0d done", i);
    end
    check(q.size(), 0);
    end_of_test();
  end
endmodule
